//--- lsi_consts.svh
// Register offsets, field positions and protocol constants of the light sensor interrupt block
`ifndef LSI_CONSTS_SVH
`define LSI_CONSTS_SVH
`define LSI_REG_INTCTL 5'h02
`define LSI_REG_SRC 5'h03
`define LSI_REG_THL_LO 5'h08
`define LSI_REG_THL_HI 5'h09
`define LSI_REG_THH_LO 5'h0a
`define LSI_REG_THH_HI 5'h0b
`define LSI_INTCTL_RST 8'h00
`define LSI_SRC_RST 8'h00
`define LSI_INTCTL_WMASK 8'h77
`define LSI_SRC_WMASK 8'h03
`define LSI_STOP_BIT 6
`define LSI_MODE_HI 5
`define LSI_MODE_LO 4
`define LSI_PERS_HI 3
`define LSI_PERS_LO 0
`define LSI_CMD_BIT 7
`define LSI_ACT_HI 6
`define LSI_ACT_LO 5
`define LSI_ACT_CLEAR 2'h3
`define LSI_ARA_ADDR 7'h0c
`define LSI_DEV_ADDR 7'h2a
`endif

//--- lsi_pkg.sv
// Types shared by the light sensor interrupt block
package lsi_pkg;
    // Serial slave states, Gray coded along address, ack and byte phases
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_AACK = 3'h3,
        ST_WBYTE = 3'h2,
        ST_WACK = 3'h6,
        ST_RBYTE = 3'h7,
        ST_RACK = 3'h5
    } lsi_state_t;

    // Interrupt style selection
    typedef enum logic [1:0] {
        MODE_OFF = 2'h0,
        MODE_LEVEL = 2'h1,
        MODE_ALERT = 2'h2,
        MODE_FORCE = 2'h3
    } lsi_mode_t;

    // Complete state of the top module
    typedef struct packed {
        lsi_state_t st;
        logic [3:0] bitc;
        logic [7:0] sh;
        logic rd;
        logic ara;
        logic first;
        logic lost;
        logic [4:0] ptr;
        logic [7:0] ctrl;
        logic [7:0] src;
        logic [15:0] thl;
        logic [15:0] thh;
        logic pend;
        logic [3:0] pcnt;
        logic force_req;
        logic scl_p;
        logic sda_p;
        logic sda_oe;
        logic int_o;
        logic int_oe;
        logic halt;
    } lsi_regs_t;
endpackage

//--- lsi_sync.sv
// Two flip-flop synchroniser for one asynchronous input
`timescale 1ns/10ps
module lsi_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta_q <= 1'b1;
            q <= 1'b1;
        end
        else
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

//--- lsi_top.sv
// Threshold interrupt logic of a colour light sensor with its serial register slave
`timescale 1ns/10ps
`include "lsi_consts.svh"
module lsi_top #(
    parameter logic [6:0] DEV_ADDR = `LSI_DEV_ADDR // Arbitrary neutral value
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic int_o,
    output logic int_oe,
    input wire logic [15:0] adc_ch0,
    input wire logic [15:0] adc_ch1,
    input wire logic [15:0] adc_ch2,
    input wire logic [15:0] adc_ch3,
    input wire logic adc_valid,
    output logic adc_halt
);
    lsi_pkg::lsi_regs_t q;
    lsi_pkg::lsi_regs_t d;
    logic scl_s;
    logic sda_s;
    logic scl_r;
    logic scl_f;
    logic start_c;
    logic stop_c;
    logic [15:0] sel_val;
    logic out_win;
    logic alert_mode;
    logic clr_cmd;
    logic clr_ara;
    logic [7:0] rd_val;
    logic [7:0] b;

    // Bus pins come from another clock domain
    lsi_sync u_sync_scl (
        .clk(clk),
        .rst_n(rst_n),
        .d(scl_i),
        .q(scl_s)
    );
    lsi_sync u_sync_sda (
        .clk(clk),
        .rst_n(rst_n),
        .d(sda_i),
        .q(sda_s)
    );

    // Bus edges and start or stop conditions
    assign scl_r = scl_s & ~q.scl_p;
    assign scl_f = ~scl_s & q.scl_p;
    assign start_c = scl_s & q.scl_p & q.sda_p & ~sda_s;
    assign stop_c = scl_s & q.scl_p & ~q.sda_p & sda_s;
    assign alert_mode = q.ctrl[`LSI_MODE_HI];

    // Selected channel and window test
    always_comb
    begin
        case (q.src[1:0])
            2'h0: sel_val = adc_ch0;
            2'h1: sel_val = adc_ch1;
            2'h2: sel_val = adc_ch2;
            default: sel_val = adc_ch3;
        endcase
        out_win = (sel_val < q.thl) || (sel_val > q.thh);
    end

    // Register read mux, unmapped offsets read as zero
    always_comb
    begin
        if (q.ptr == `LSI_REG_INTCTL)
            rd_val = q.ctrl;
        else if (q.ptr == `LSI_REG_SRC)
            rd_val = q.src;
        else if (q.ptr == `LSI_REG_THL_LO)
            rd_val = q.thl[7:0];
        else if (q.ptr == `LSI_REG_THL_HI)
            rd_val = q.thl[15:8];
        else if (q.ptr == `LSI_REG_THH_LO)
            rd_val = q.thh[7:0];
        else if (q.ptr == `LSI_REG_THH_HI)
            rd_val = q.thh[15:8];
        else
            rd_val = 8'h00;
    end

    // Next state of slave, registers and interrupt
    always_comb
    begin
        d = q;
        clr_cmd = 1'b0;
        clr_ara = 1'b0;
        b = q.sh;
        d.scl_p = scl_s;
        d.sda_p = sda_s;
        if (start_c)
        begin
            d.st = lsi_pkg::ST_ADDR;
            d.bitc = 4'h0;
            d.sda_oe = 1'b0;
        end
        else if (stop_c)
        begin
            d.st = lsi_pkg::ST_IDLE;
            d.sda_oe = 1'b0;
            if (q.force_req)
            begin
                d.pend = 1'b1;
                d.force_req = 1'b0;
            end
        end
        else
        begin
            case (q.st)
                lsi_pkg::ST_ADDR:
                begin
                    if (scl_r)
                    begin
                        d.sh = {q.sh[6:0], sda_s};
                        d.bitc = q.bitc + 4'h1;
                    end
                    else if (scl_f && q.bitc == 4'h8)
                    begin
                        d.ara = 1'b0;
                        d.rd = q.sh[0];
                        d.first = ~q.sh[0];
                        d.st = lsi_pkg::ST_AACK;
                        d.sda_oe = 1'b1;
                        if (q.sh[7:1] == `LSI_ARA_ADDR && q.sh[0])
                        begin
                            // Only an alerting device answers the query
                            d.ara = 1'b1;
                            if (!(q.pend && alert_mode))
                            begin
                                d.st = lsi_pkg::ST_IDLE;
                                d.sda_oe = 1'b0;
                            end
                        end
                        else if (q.sh[7:1] != DEV_ADDR)
                        begin
                            d.st = lsi_pkg::ST_IDLE;
                            d.sda_oe = 1'b0;
                        end
                    end
                end
                lsi_pkg::ST_AACK:
                begin
                    if (scl_f)
                    begin
                        d.bitc = 4'h0;
                        d.lost = 1'b0;
                        if (q.rd)
                        begin
                            d.sh = q.ara ? {DEV_ADDR, 1'b1} : rd_val;
                            d.sda_oe = ~d.sh[7];
                            d.st = lsi_pkg::ST_RBYTE;
                        end
                        else
                        begin
                            d.sda_oe = 1'b0;
                            d.st = lsi_pkg::ST_WBYTE;
                        end
                    end
                end
                lsi_pkg::ST_WBYTE:
                begin
                    if (scl_r)
                    begin
                        d.sh = {q.sh[6:0], sda_s};
                        d.bitc = q.bitc + 4'h1;
                    end
                    else if (scl_f && q.bitc == 4'h8)
                    begin
                        d.st = lsi_pkg::ST_WACK;
                        d.sda_oe = 1'b1;
                        d.first = 1'b0;
                        if (q.first)
                        begin
                            if (b[`LSI_CMD_BIT])
                                d.ptr = b[4:0];
                            if (b[`LSI_ACT_HI:`LSI_ACT_LO] == `LSI_ACT_CLEAR)
                                clr_cmd = 1'b1;
                        end
                        else
                        begin
                            d.ptr = q.ptr + 5'h01;
                            if (q.ptr == `LSI_REG_INTCTL)
                            begin
                                d.ctrl = b & `LSI_INTCTL_WMASK;
                                if (b[`LSI_MODE_HI:`LSI_MODE_LO] == lsi_pkg::MODE_FORCE)
                                    d.force_req = 1'b1;
                            end
                            else if (q.ptr == `LSI_REG_SRC)
                                d.src = b & `LSI_SRC_WMASK;
                            else if (q.ptr == `LSI_REG_THL_LO)
                                d.thl[7:0] = b;
                            else if (q.ptr == `LSI_REG_THL_HI)
                                d.thl[15:8] = b;
                            else if (q.ptr == `LSI_REG_THH_LO)
                                d.thh[7:0] = b;
                            else if (q.ptr == `LSI_REG_THH_HI)
                                d.thh[15:8] = b;
                        end
                    end
                end
                lsi_pkg::ST_WACK:
                begin
                    if (scl_f)
                    begin
                        d.sda_oe = 1'b0;
                        d.bitc = 4'h0;
                        d.st = lsi_pkg::ST_WBYTE;
                    end
                end
                lsi_pkg::ST_RBYTE:
                begin
                    if (scl_r)
                    begin
                        d.bitc = q.bitc + 4'h1;
                        // Released a one but the wire is low: a lower address won
                        if (q.ara && q.sh[7] && !sda_s)
                            d.lost = 1'b1;
                    end
                    else if (scl_f && q.bitc == 4'h8)
                    begin
                        d.sda_oe = 1'b0;
                        d.st = lsi_pkg::ST_RACK;
                        if (q.ara && !q.lost)
                            clr_ara = 1'b1;
                    end
                    else if (scl_f)
                    begin
                        d.sh = {q.sh[6:0], 1'b0};
                        d.sda_oe = ~q.sh[6] & ~q.lost;
                    end
                end
                lsi_pkg::ST_RACK:
                begin
                    if (scl_r)
                    begin
                        d.st = sda_s ? lsi_pkg::ST_IDLE : lsi_pkg::ST_AACK;
                        if (!q.ara)
                            d.ptr = q.ptr + 5'h01;
                    end
                end
                default:
                begin
                    d.st = lsi_pkg::ST_IDLE;
                end
            endcase
        end
        // Clears first, so a same-cycle event below still sets the flag
        if (clr_cmd || clr_ara)
            d.pend = 1'b0;
        if (adc_valid && !q.halt)
        begin
            if (!out_win)
                d.pcnt = 4'h0;
            else if (q.pcnt >= q.ctrl[`LSI_PERS_HI:`LSI_PERS_LO])
                d.pend = 1'b1;
            else
                d.pcnt = q.pcnt + 4'h1;
        end
        d.int_o = 1'b0;
        d.int_oe = d.pend && (d.ctrl[`LSI_MODE_HI:`LSI_MODE_LO] != lsi_pkg::MODE_OFF);
        d.halt = d.pend && d.ctrl[`LSI_STOP_BIT];
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            q <= '0;
            q.ctrl <= `LSI_INTCTL_RST;
            q.src <= `LSI_SRC_RST;
            q.scl_p <= 1'b1;
            q.sda_p <= 1'b1;
        end
        else
            q <= d;
    end

    assign sda_o = 1'b0;
    assign sda_oe = q.sda_oe;
    assign int_o = q.int_o;
    assign int_oe = q.int_oe;
    assign adc_halt = q.halt;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_int_pulls_low: assert property (int_oe |-> !int_o)
        else $error("interrupt pin driven high");
    a_mode_off_quiet: assert property (
        (q.ctrl[5:4] == 2'h0) [*2] |-> !int_oe)
        else $error("interrupt driven while disabled");
    a_pend_drives_pin: assert property (
        (q.pend && q.ctrl[5:4] != 2'h0) ##1 (q.pend && q.ctrl[5:4] != 2'h0) |-> int_oe)
        else $error("pending interrupt not on pin");
    a_persist_fires: assert property (
        adc_valid && !q.halt && out_win && q.pcnt >= q.ctrl[3:0] |=> q.pend)
        else $error("persistence reached without interrupt");
    a_inside_resets: assert property (
        adc_valid && !q.halt && !out_win |=> q.pcnt == 4'h0)
        else $error("persistence count kept on inside result");
    a_clear_cause: assert property (
        $fell(q.pend) |-> $past(clr_cmd || clr_ara))
        else $error("interrupt cleared without clear cycle");
    a_force_at_stop: assert property (stop_c && q.force_req |=> q.pend)
        else $error("forced interrupt missing after write");
    a_lost_keeps: assert property (
        q.st == lsi_pkg::ST_RBYTE && q.ara && q.lost && q.pend |=> q.pend)
        else $error("arbitration loser lost its interrupt");
    a_halt_track: assert property (
        q.pend && q.ctrl[6] |-> adc_halt)
        else $error("integration not halted on interrupt");
    a_ara_only_alert: assert property (clr_ara |-> alert_mode)
        else $error("alert response cleared outside alert mode");

    c_ara_clear: cover property (clr_ara);
    c_cmd_clear: cover property (clr_cmd && q.pend);
    c_force: cover property (stop_c && q.force_req);
    c_lost: cover property (q.ara && q.lost && scl_f && q.bitc == 4'h8);
endmodule

//--- lsi_host.sv
// SMBus host model that drives the bus clock and pulls the data wire
`timescale 1ns/10ps
module lsi_host (
    input wire logic sda,
    output logic scl,
    output logic sda_pull
);
    localparam int Q = 200; // Quarter of the 800 ns bus clock period
    logic hp; // Host pulls data low
    logic rp; // Rival device pulls data low
    logic [7:0] rv_byte; // Rival alert answer, all ones when absent
    assign sda_pull = hp | rp;
    initial
    begin
        scl = 1'b1;
        hp = 1'b0;
        rp = 1'b0;
        rv_byte = 8'hff;
    end
    // Data moves a quarter period after the clock falls, so hold is never short
    task automatic bitx(input logic b, input logic r, output logic s);
    begin
        #(Q);
        hp = ~b;
        rp = ~r;
        #(Q);
        scl = 1'b1;
        #(2*Q);
        s = sda;
        scl = 1'b0;
    end
    endtask
    // Host never acks, so every read ends after one byte
    task automatic bytex(input logic [7:0] tx, input logic [7:0] rb,
        output logic [7:0] rx, output logic ack);
        logic s;
    begin
        for (int i = 7; i >= 0; i--)
        begin
            bitx(tx[i], rb[i], s);
            rx[i] = s;
        end
        bitx(1'b1, 1'b1, s);
        ack = ~s;
    end
    endtask
    // Bus idles with the clock high; odd offset keeps it off the system clock phase
    task automatic start_c();
    begin
        #(Q + 13);
        scl = 1'b1;
        #(2*Q);
        hp = 1'b1;
        #(2*Q);
        scl = 1'b0;
    end
    endtask
    task automatic stop_c();
    begin
        #(Q);
        hp = 1'b1;
        rp = 1'b0;
        #(Q);
        scl = 1'b1;
        #(2*Q);
        hp = 1'b0;
        #(4*Q);
    end
    endtask
    // Address, n written bytes, and one read byte when the address asks to read
    task automatic xact(input logic [7:0] a, input int n, input logic [31:0] d,
        output logic ok, output logic [7:0] rx);
        logic k;
    begin
        start_c();
        bytex(a, 8'hff, rx, ok);
        for (int i = 0; i < n; i++)
            bytex(d[8*i +: 8], 8'hff, rx, k);
        if (a[0])
            bytex(8'hff, rv_byte, rx, k);
        stop_c();
    end
    endtask
endmodule

//--- tb_top.sv
// Testbench of the light sensor interrupt block against a behavioural model
`timescale 1ns/10ps
module tb_top;
    localparam logic [6:0] DEV = 7'h35; // Arbitrary bus address
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] adc [4];
    logic adc_valid = 1'b0;
    logic scl, pull, sda_oe, sda_o, int_o, int_oe, adc_halt;
    logic m_pend = 1'b0;
    logic [7:0] ctrl = 8'h00;
    logic [7:0] src = 8'h00;
    logic [15:0] lo = 16'h0;
    logic [15:0] hi = 16'h0;
    int m_cnt = 0;
    int num_errors = 0;
    int n_compared = 0;
    int seed = 9080;
    int cyc = 0;
    // Both wires have pull-ups, so released means high
    wire sda_w = ~((sda_oe & ~sda_o) | pull);
    wire int_w = ~(int_oe & ~int_o);
    always #50 clk = ~clk;
    lsi_top #(.DEV_ADDR(DEV)) u_lsi_top (
        .clk(clk),
        .rst_n(rst_n),
        .scl_i(scl),
        .sda_i(sda_w),
        .sda_o(sda_o),
        .sda_oe(sda_oe),
        .int_o(int_o),
        .int_oe(int_oe),
        .adc_ch0(adc[0]),
        .adc_ch1(adc[1]),
        .adc_ch2(adc[2]),
        .adc_ch3(adc[3]),
        .adc_valid(adc_valid),
        .adc_halt(adc_halt)
    );
    lsi_host u_lsi_host (
        .sda(sda_w),
        .scl(scl),
        .sda_pull(pull)
    );
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    begin
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    end
    endtask
    task automatic report_and_stop();
    begin
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask
    // Hang guard, far above the roughly 9.5k cycles the sequence needs
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            num_errors++;
            report_and_stop();
        end
    end
    task automatic pins();
    begin
        @(negedge clk);
        check("int_pin", 8'(int_w), 8'(!(m_pend && ctrl[5:4] != 2'h0)));
        check("adc_halt", 8'(adc_halt), 8'(m_pend && ctrl[6]));
    end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic ok;
        logic [7:0] rx;
    begin
        u_lsi_host.xact({DEV, 1'b0}, 2, {16'h0, d, 3'h4, a}, ok, rx);
        check("wr_ack", 8'(ok), 8'h01);
        if (a == 5'h02)
        begin
            ctrl = d & 8'h77;
            m_pend = m_pend | (d[5:4] == 2'h3);
        end
        if (a == 5'h03)
            src = d & 8'h03;
        pins();
    end
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] exp);
        logic ok;
        logic [7:0] rx;
    begin
        u_lsi_host.xact({DEV, 1'b0}, 1, {27'h4, a}, ok, rx);
        u_lsi_host.xact({DEV, 1'b1}, 0, 32'h0, ok, rx);
        check("rd_data", rx, exp);
    end
    endtask
    // Selected channel gets v, the others noise; results are ignored while halted
    task automatic conv(input logic [15:0] v);
    begin
        @(posedge clk);
        for (int i = 0; i < 4; i++)
            adc[i] <= (i == src) ? v : 16'($random(seed));
        adc_valid <= 1'b1;
        if (!(m_pend && ctrl[6]))
        begin
            if (v < lo || v > hi)
            begin
                if (m_cnt >= ctrl[3:0])
                    m_pend = 1'b1;
                else
                    m_cnt++;
            end
            else
                m_cnt = 0;
        end
        @(posedge clk);
        adc_valid <= 1'b0;
        repeat (3) @(posedge clk);
        pins();
    end
    endtask
    // Inside result afterwards once the window is set, so no stale count carries over
    task automatic clr();
        logic ok;
        logic [7:0] rx;
    begin
        u_lsi_host.xact({DEV, 1'b0}, 1, 32'h60, ok, rx);
        m_pend = 1'b0;
        pins();
        conv(16'h1800);
    end
    endtask
    task automatic ara(input logic [7:0] rv, input logic ack_exp, input logic [7:0] exp);
        logic ok;
        logic [7:0] rx;
    begin
        u_lsi_host.rv_byte = rv;
        u_lsi_host.xact({7'h0c, 1'b1}, 0, 32'h0, ok, rx);
        u_lsi_host.rv_byte = 8'hff;
        check("ara_ack", 8'(ok), 8'(ack_exp));
        if (ack_exp)
            check("ara_data", rx, exp);
        m_pend = m_pend && !(ack_exp && rv == 8'hff);
        pins();
    end
    endtask
    // Window edges, inside and outside, declared ahead of the sequence that walks them
    localparam logic [15:0] lo_edges [6] = '{16'h1000, 16'h2000, 16'h0fff,
        16'h1800, 16'h2001, 16'h2001};
    initial
    begin
        for (int i = 0; i < 4; i++)
            adc[i] = 16'h0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(5'h02, 8'h00);
        rd(5'h03, 8'h00);
        rd(5'h10, 8'h00);
        wr(5'h02, 8'hff);
        rd(5'h02, 8'h77);
        clr();
        wr(5'h03, 8'hff);
        rd(5'h03, 8'h03);
        wr(5'h08, 8'h00);
        wr(5'h09, 8'h10);
        wr(5'h0a, 8'h00);
        wr(5'h0b, 8'h20);
        lo = 16'h1000;
        hi = 16'h2000;
        rd(5'h0b, 8'h20);
        // Each channel with persistence equal to its number; edges then noise
        for (int ch = 0; ch < 4; ch++)
        begin
            wr(5'h03, 8'(ch));
            wr(5'h02, 8'(8'h10 + ch));
            foreach (lo_edges[k])
                conv(lo_edges[k]);
            repeat (8)
                conv(16'($random(seed)) & 16'h3fff);
            clr();
        end
        wr(5'h02, 8'h00);
        conv(16'h0000);
        wr(5'h02, 8'h10);
        clr();
        wr(5'h02, 8'h20);
        conv(16'h3000);
        ara(8'hff, 1'b1, {DEV, 1'b1});
        ara(8'hff, 1'b0, 8'h00);
        wr(5'h02, 8'h30);
        ara(8'h21, 1'b1, 8'h21);
        ara(8'hff, 1'b1, {DEV, 1'b1});
        wr(5'h02, 8'h10);
        conv(16'h0000);
        ara(8'hff, 1'b0, 8'h00);
        clr();
        wr(5'h02, 8'h50);
        conv(16'h0000);
        conv(16'h1800);
        clr();
        report_and_stop();
    end
endmodule
